// ===== fog_top.sv
// pin function configuration, diagnosis and wake reporting
`default_nettype none
`include "fog_regs.svh"
module fog_top #(
    parameter int DUTY_W = 8,
    parameter int INT_W = 12
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire fog_pkg::fog_mode_t MODE_IN,
    input wire logic SOFT_RESET_IN,
    input wire logic FAILURE_IN,
    input wire logic PWM_ON_IN,
    input wire logic TIMER_ON_IN,
    input wire logic OVERCURRENT_IN,
    input wire logic OPEN_LOAD_IN,
    input wire logic PIN_LEVEL_IN,
    output logic PIN_LOW_OE_OUT,
    output logic PIN_HIGH_OE_OUT,
    output logic PULL_UP_OUT,
    output logic PULL_DOWN_OUT,
    output logic WAKE_CAPABLE_OUT,
    output logic DIAG_EN_OUT,
    output logic LEARN_START_OUT,
    output logic INT_OUT,
    output logic SUPPLY_WAKE_OUT,
    output logic [DUTY_W-1:0] PWM_DUTY_OUT,
    output logic [7:0] PWM_FREQ_OUT,
    output logic [7:0] TIMER_OUT
);
    import fog_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic fog_func_t decode_func(input logic [2:0] code);
        if (code == 3'h4) begin
            decode_func = FOG_FN_OFF;
        end else if (code == 3'h5) begin
            decode_func = FOG_FN_WAKE;
        end else if (code == 3'h6) begin
            decode_func = FOG_FN_LOW;
        end else if (code == 3'h7) begin
            decode_func = FOG_FN_HIGH;
        end else if (code == 3'h3) begin
            decode_func = FOG_FN_CYCLIC;
        end else begin
            decode_func = FOG_FN_FAIL;
        end
    endfunction

    function automatic logic is_switch(input fog_func_t fn);
        is_switch = (fn == FOG_FN_LOW) || (fn == FOG_FN_HIGH) || (fn == FOG_FN_CYCLIC);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [2:0] func_reg;
    logic lock_reg;
    logic test_reg;
    logic [1:0] pull_reg;
    logic [DUTY_W-1:0] duty_reg;
    logic [7:0] freq_reg;
    logic [7:0] timer_reg;
    logic oc_reg;
    logic ol_reg;
    logic fail_flag_reg;
    logic wake_event_reg;
    logic level_reg;
    logic level_shown_reg;
    logic fail_latched_reg;
    fog_mode_t mode_prev_reg;
    logic int_start;
    logic int_busy;
    logic timer_was_zero_reg;
    logic wk_level;
    logic wk_edge;
    fog_func_t fn;
    logic in_restart_fs;
    logic entered_restart_fs;
    logic sw_on;
    logic oc_event;
    logic ol_event;
    logic write_ok;

    assign fn = decode_func(func_reg);
    assign in_restart_fs = (MODE_IN == FOG_MODE_RESTART) || (MODE_IN == FOG_MODE_FAILSAFE);
    assign entered_restart_fs = in_restart_fs && (mode_prev_reg != MODE_IN);
    // switch on-time: generator or timer
    assign sw_on = (fn == FOG_FN_CYCLIC) ? TIMER_ON_IN : PWM_ON_IN;
    assign oc_event = is_switch(fn) && sw_on && OVERCURRENT_IN;
    assign ol_event = (fn == FOG_FN_HIGH) && sw_on && OPEN_LOAD_IN;
    assign write_ok = WR_IN && (MODE_IN == FOG_MODE_NORMAL);

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            mode_prev_reg <= FOG_MODE_INIT;
        end else begin
            mode_prev_reg <= MODE_IN;
        end
    end

    // ----------------------------------------
    // configuration
    // ----------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            func_reg <= 3'(`FOG_PIN_CTRL_RST);
            lock_reg <= 1'b0;
            pull_reg <= 2'h0;
        end else if (is_switch(fn) && (oc_event || entered_restart_fs)) begin
            func_reg <= `FOG_FUNC_OFF;
        end else if (SOFT_RESET_IN) begin
            if (!lock_reg) begin
                func_reg <= 3'(`FOG_PIN_CTRL_RST);
                pull_reg <= 2'h0;
            end
        end else if (write_ok && ADDR_IN == `FOG_ADDR_PIN_CTRL) begin
            lock_reg <= WDATA_IN[7];
            pull_reg <= WDATA_IN[5:4];
            // locked field refuses change; unlock first
            if (!lock_reg) begin
                func_reg <= WDATA_IN[2:0];
            end
        end
    end

    // test bit can be written in any function and in any mode except restart
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            test_reg <= 1'b0;
        end else if (MODE_IN == FOG_MODE_RESTART) begin
            test_reg <= 1'b0;
        end else if (WR_IN && ADDR_IN == `FOG_ADDR_PIN_CTRL) begin
            test_reg <= WDATA_IN[3];
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN || SOFT_RESET_IN) begin
            duty_reg <= '0;
            freq_reg <= 8'h00;
            timer_reg <= 8'h00;
        end else if (write_ok) begin
            if (ADDR_IN == `FOG_ADDR_PWM_DUTY) begin
                duty_reg <= WDATA_IN[DUTY_W-1:0];
            end else if (ADDR_IN == `FOG_ADDR_PWM_FREQ) begin
                freq_reg <= WDATA_IN;
            end else if (ADDR_IN == `FOG_ADDR_TIMER) begin
                timer_reg <= WDATA_IN;
            end
        end
    end

    // ----------------------------------------
    // status flags: set wins over clear
    // ----------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            oc_reg <= 1'b0;
            ol_reg <= 1'b0;
            fail_flag_reg <= 1'b0;
        end else begin
            if (oc_event) begin
                oc_reg <= 1'b1;
            end else if (WR_IN && ADDR_IN == `FOG_ADDR_CLEAR && WDATA_IN[0]) begin
                oc_reg <= 1'b0;
            end
            if (ol_event) begin
                ol_reg <= 1'b1;
            end else if (WR_IN && ADDR_IN == `FOG_ADDR_CLEAR && WDATA_IN[1]) begin
                ol_reg <= 1'b0;
            end
            // flag set in every function, still clearable
            if (FAILURE_IN) begin
                fail_flag_reg <= 1'b1;
            end else if (WR_IN && ADDR_IN == `FOG_ADDR_CLEAR && WDATA_IN[2]) begin
                fail_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            fail_latched_reg <= 1'b0;
        end else if (FAILURE_IN) begin
            fail_latched_reg <= 1'b1;
        end else if (MODE_IN == FOG_MODE_NORMAL && !fail_flag_reg) begin
            fail_latched_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // wake input
    // ----------------------------------------
    fog_wake_filter #(
        .WIDTH(12)
    ) u_filter (
        .clk_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .enable_in(fn == FOG_FN_WAKE),
        .level_in(PIN_LEVEL_IN),
        .level_out(wk_level),
        .edge_out(wk_edge)
    );

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            wake_event_reg <= 1'b0;
        end else if (MODE_IN == FOG_MODE_FAILSAFE && mode_prev_reg != FOG_MODE_FAILSAFE) begin
            wake_event_reg <= 1'b0;
        end else if (wk_edge) begin
            wake_event_reg <= 1'b1;
        end else if (WR_IN && ADDR_IN == `FOG_ADDR_CLEAR && WDATA_IN[3]) begin
            wake_event_reg <= 1'b0;
        end
    end

    // readable level copy frozen in sleep and fail-safe
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            level_reg <= 1'b0;
            level_shown_reg <= 1'b0;
        end else begin
            if (fn == FOG_FN_WAKE) begin
                level_reg <= wk_level;
            end else if (fn == FOG_FN_LOW || fn == FOG_FN_HIGH) begin
                level_reg <= PIN_LEVEL_IN;
            end
            if (MODE_IN == FOG_MODE_NORMAL || MODE_IN == FOG_MODE_STOP ||
                MODE_IN == FOG_MODE_INIT || MODE_IN == FOG_MODE_RESTART) begin
                level_shown_reg <= level_reg;
            end
        end
    end

    // ----------------------------------------
    // interrupt pulse and supply wake
    // ----------------------------------------
    assign int_start = wk_edge && !int_busy &&
        (MODE_IN == FOG_MODE_NORMAL || MODE_IN == FOG_MODE_STOP);

    fog_timer #(
        .WIDTH(INT_W)
    ) u_int_timer (
        .clk_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .start_in(int_start),
        .load_in(INT_W'(`FOG_INT_CYC)),
        .busy_out(int_busy),
        .done_out()
    );

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            INT_OUT <= 1'b0;
            SUPPLY_WAKE_OUT <= 1'b0;
        end else begin
            INT_OUT <= int_start || int_busy;
            if (wk_edge && MODE_IN == FOG_MODE_SLEEP) begin
                SUPPLY_WAKE_OUT <= 1'b1;
            end else if (MODE_IN != FOG_MODE_SLEEP) begin
                SUPPLY_WAKE_OUT <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            PIN_LOW_OE_OUT <= 1'b0;
            PIN_HIGH_OE_OUT <= 1'b0;
            PULL_UP_OUT <= 1'b0;
            PULL_DOWN_OUT <= 1'b0;
            WAKE_CAPABLE_OUT <= 1'b0;
            DIAG_EN_OUT <= 1'b0;
            LEARN_START_OUT <= 1'b0;
            timer_was_zero_reg <= 1'b1;
        end else begin
            // fail output drives low only when selected
            PIN_LOW_OE_OUT <= ((fn == FOG_FN_FAIL) && (fail_latched_reg || test_reg)) ||
                ((fn == FOG_FN_LOW) && !in_restart_fs && !oc_event && PWM_ON_IN);
            PIN_HIGH_OE_OUT <= !in_restart_fs && !oc_event &&
                (((fn == FOG_FN_HIGH) && PWM_ON_IN) || ((fn == FOG_FN_CYCLIC) && TIMER_ON_IN));
            PULL_UP_OUT <= (fn == FOG_FN_WAKE) && (pull_reg == 2'h2);
            PULL_DOWN_OUT <= (fn == FOG_FN_WAKE) && (pull_reg == 2'h1);
            WAKE_CAPABLE_OUT <= (fn == FOG_FN_WAKE);
            DIAG_EN_OUT <= is_switch(fn) && (fn != FOG_FN_FAIL);
            timer_was_zero_reg <= (timer_reg == 8'h00);
            LEARN_START_OUT <= (fn == FOG_FN_CYCLIC) && timer_was_zero_reg && (timer_reg != 8'h00);
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            PWM_DUTY_OUT <= '0;
            PWM_FREQ_OUT <= 8'h00;
            TIMER_OUT <= 8'h00;
        end else begin
            PWM_DUTY_OUT <= duty_reg;
            PWM_FREQ_OUT <= freq_reg;
            TIMER_OUT <= timer_reg;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            if (ADDR_IN == `FOG_ADDR_PIN_CTRL) begin
                RDATA_OUT <= {lock_reg, 1'b0, pull_reg, test_reg, func_reg};
            end else if (ADDR_IN == `FOG_ADDR_PWM_DUTY) begin
                RDATA_OUT <= 8'(duty_reg);
            end else if (ADDR_IN == `FOG_ADDR_PWM_FREQ) begin
                RDATA_OUT <= freq_reg;
            end else if (ADDR_IN == `FOG_ADDR_TIMER) begin
                RDATA_OUT <= timer_reg;
            end else if (ADDR_IN == `FOG_ADDR_STATUS) begin
                RDATA_OUT <= {5'h00, fail_flag_reg, ol_reg, oc_reg};
            end else if (ADDR_IN == `FOG_ADDR_WAKE_STAT) begin
                RDATA_OUT <= {7'h00, wake_event_reg};
            end else if (ADDR_IN == `FOG_ADDR_LEVEL_STAT) begin
                RDATA_OUT <= {7'h00, level_shown_reg};
            end else begin
                RDATA_OUT <= 8'h00;
            end
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== fog_regs.svh
// constants and register map of the pin function configuration block
// How it works
// - three-bit field picks fail, off, wake, switches
// - fail function keeps switch diagnosis off
// - wake input blanks, then filters its level
// - wake input is wake capable, pull follows select
// - pin wake event stored, cleared entering fail-safe
// - level status shown, held in sleep and fail-safe
// - wake edge pulses interrupt, restart only sets event
// - wake edge in sleep enables main supply
// - low-side switch follows shared pulse generator
// - low-side overcurrent checked on-time, disables switch
// - high-side switch follows shared pulse generator
// - high-side open load, overcurrent on-time only
// - cyclic sense timer start begins learning cycle
// - cyclic sense overcurrent shutdown, timer keeps running
// - shutdown rewrites field to off
// - wake reference starts low, no learning
// - non-fail function ignores failures and test bit
// - failure-driven fail output persists through restart
// - soft reset keeps locked config, clears timer, pulse
// - reconfigure only in normal except test bit, switches off in restart and fail-safe
`ifndef FOG_REGS_SVH
`define FOG_REGS_SVH
`define FOG_ADDR_PIN_CTRL 4'h0
`define FOG_ADDR_PWM_DUTY 4'h1
`define FOG_ADDR_PWM_FREQ 4'h2
`define FOG_ADDR_TIMER 4'h3
`define FOG_ADDR_STATUS 4'h4
`define FOG_ADDR_WAKE_STAT 4'h5
`define FOG_ADDR_LEVEL_STAT 4'h6
`define FOG_ADDR_CLEAR 4'h7
`define FOG_PIN_CTRL_RST 8'h00
`define FOG_FUNC_OFF 3'h4
`define FOG_BLANK_NS 40000
`define FOG_FILTER_NS 13000
`define FOG_CLK_NS 50
`define FOG_BLANK_CYC ((`FOG_BLANK_NS + `FOG_CLK_NS - 1) / `FOG_CLK_NS)
`define FOG_FILTER_CYC ((`FOG_FILTER_NS + `FOG_CLK_NS - 1) / `FOG_CLK_NS)
`define FOG_INT_CYC 2000
`endif

// ===== fog_pkg.sv
// types of the pin function configuration block
`default_nettype none
package fog_pkg;
    typedef enum logic [2:0] {
        FOG_MODE_NORMAL = 3'b000,
        FOG_MODE_STOP = 3'b001,
        FOG_MODE_SLEEP = 3'b010,
        FOG_MODE_INIT = 3'b011,
        FOG_MODE_RESTART = 3'b100,
        FOG_MODE_FAILSAFE = 3'b101
    } fog_mode_t;
    typedef enum logic [2:0] {
        FOG_FN_FAIL = 3'b000,
        FOG_FN_OFF = 3'b001,
        FOG_FN_WAKE = 3'b010,
        FOG_FN_LOW = 3'b011,
        FOG_FN_HIGH = 3'b100,
        FOG_FN_CYCLIC = 3'b101
    } fog_func_t;
    typedef enum logic [1:0] {
        FOG_WK_IDLE = 2'b00,
        FOG_WK_BLANK = 2'b01,
        FOG_WK_RUN = 2'b10
    } fog_wk_state_t;
endpackage
`default_nettype wire

// ===== fog_timer.sv
// down counter used for interrupt pulse timing
`default_nettype none
module fog_timer #(
    parameter int WIDTH = 12
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [WIDTH-1:0] load_in,
    output logic busy_out,
    output logic done_out
);
    logic [WIDTH-1:0] count_reg;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_reg <= '0;
            done_out <= 1'b0;
        end else if (start_in) begin
            count_reg <= load_in;
            done_out <= 1'b0;
        end else begin
            done_out <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
            if (count_reg != '0) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
    assign busy_out = (count_reg != '0);
endmodule
`default_nettype wire

// ===== fog_wake_filter.sv
// wake input blanking and level filter
`default_nettype none
`include "fog_regs.svh"
module fog_wake_filter #(
    parameter int WIDTH = 12
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic level_in,
    output logic level_out,
    output logic edge_out
);
    import fog_pkg::*;
    fog_wk_state_t state_reg;
    logic [WIDTH-1:0] count_reg;
    logic stable_reg;
    logic cand_reg;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enable_in) begin
            state_reg <= FOG_WK_IDLE;
            count_reg <= '0;
            cand_reg <= 1'b0;
        end else begin
            case (state_reg)
                FOG_WK_IDLE: begin
                    state_reg <= FOG_WK_BLANK;
                    count_reg <= WIDTH'(`FOG_BLANK_CYC);
                end
                FOG_WK_BLANK: begin
                    // level ignored until blanking expires
                    if (count_reg == '0) begin
                        state_reg <= FOG_WK_RUN;
                        cand_reg <= level_in;
                        count_reg <= WIDTH'(`FOG_FILTER_CYC);
                    end else begin
                        count_reg <= count_reg - 1'b1;
                    end
                end
                FOG_WK_RUN: begin
                    if (level_in != cand_reg) begin
                        cand_reg <= level_in;
                        count_reg <= WIDTH'(`FOG_FILTER_CYC);
                    end else if (count_reg != '0) begin
                        count_reg <= count_reg - 1'b1;
                    end
                end
                default: state_reg <= FOG_WK_IDLE;
            endcase
        end
    end
    // reference survives reconfiguration: no learning
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stable_reg <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            edge_out <= 1'b0;
            if (enable_in && state_reg == FOG_WK_RUN && count_reg == '0 && cand_reg != stable_reg) begin
                stable_reg <= cand_reg;
                edge_out <= 1'b1;
            end
        end
    end
    assign level_out = stable_reg;
endmodule
`default_nettype wire

// ===== fog_top_asserts.sv
// port assertions of the pin function block
`default_nettype none
module fog_chk #(
    parameter int DUTY_W = 8,
    parameter int INT_W = 12
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire fog_pkg::fog_mode_t MODE_IN,
    input wire logic SOFT_RESET_IN,
    input wire logic OVERCURRENT_IN,
    input wire logic PIN_LOW_OE_OUT,
    input wire logic PIN_HIGH_OE_OUT,
    input wire logic DIAG_EN_OUT,
    input wire logic LEARN_START_OUT,
    input wire logic INT_OUT,
    input wire logic SUPPLY_WAKE_OUT,
    input wire logic [DUTY_W-1:0] PWM_DUTY_OUT,
    input wire logic [7:0] PWM_FREQ_OUT,
    input wire logic [7:0] TIMER_OUT
);
    import fog_pkg::*;
    // ----
    // properties
    // ----
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // pulse too long for a repetition
    int hi_cnt;
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN || !INT_OUT) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    int_width_a: assert property ($fell(INT_OUT) |-> hi_cnt == 2001)
        else $error("interrupt width");
    int_mode_a: assert property ($rose(INT_OUT) |-> $past(MODE_IN) inside {FOG_MODE_NORMAL, FOG_MODE_STOP})
        else $error("interrupt mode");
    supply_sleep_a: assert property ($rose(SUPPLY_WAKE_OUT) |-> $past(MODE_IN) == FOG_MODE_SLEEP)
        else $error("supply wake mode");
    sw_off_mode_a: assert property ((MODE_IN inside {FOG_MODE_RESTART, FOG_MODE_FAILSAFE})[*3]
        |-> !PIN_HIGH_OE_OUT && !DIAG_EN_OUT) else $error("switch not off");
    hs_trip_a: assert property (OVERCURRENT_IN && PIN_HIGH_OE_OUT |-> ##[1:3] !PIN_HIGH_OE_OUT)
        else $error("high side on");
    ls_trip_a: assert property (OVERCURRENT_IN && PIN_LOW_OE_OUT && DIAG_EN_OUT |-> ##[1:3] !PIN_LOW_OE_OUT)
        else $error("low side on");
    fail_keep_a: assert property (OVERCURRENT_IN && PIN_LOW_OE_OUT && !DIAG_EN_OUT && !$past(DIAG_EN_OUT)
        && !WR_IN && MODE_IN == FOG_MODE_NORMAL && $stable(MODE_IN) |=> PIN_LOW_OE_OUT)
        else $error("fail output tripped");
    duty_wr_a: assert property (WR_IN && ADDR_IN == 4'h1 && MODE_IN == FOG_MODE_NORMAL && !SOFT_RESET_IN
        |-> ##2 PWM_DUTY_OUT == $past(WDATA_IN, 2)) else $error("duty not taken");
    duty_fixed_a: assert property (WR_IN && ADDR_IN == 4'h1 && MODE_IN != FOG_MODE_NORMAL && !SOFT_RESET_IN
        |-> ##2 $stable(PWM_DUTY_OUT)) else $error("duty changed");
    soft_clear_a: assert property (SOFT_RESET_IN
        |-> ##2 PWM_DUTY_OUT == '0 && PWM_FREQ_OUT == 8'h00 && TIMER_OUT == 8'h00) else $error("settings kept");
    learn_src_a: assert property ($rose(LEARN_START_OUT)
        |-> ($past(WR_IN) && $past(ADDR_IN) == 4'h3) || ($past(WR_IN, 2) && $past(ADDR_IN, 2) == 4'h3))
        else $error("learning start");
    cover property ($rose(INT_OUT));
    cover property ($rose(SUPPLY_WAKE_OUT));
    cover property ($rose(LEARN_START_OUT));
endmodule
bind fog_top fog_chk #(.DUTY_W(DUTY_W), .INT_W(INT_W)) i_fog_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .MODE_IN(MODE_IN), .SOFT_RESET_IN(SOFT_RESET_IN),
    .OVERCURRENT_IN(OVERCURRENT_IN), .PIN_LOW_OE_OUT(PIN_LOW_OE_OUT), .PIN_HIGH_OE_OUT(PIN_HIGH_OE_OUT),
    .DIAG_EN_OUT(DIAG_EN_OUT), .LEARN_START_OUT(LEARN_START_OUT), .INT_OUT(INT_OUT),
    .SUPPLY_WAKE_OUT(SUPPLY_WAKE_OUT), .PWM_DUTY_OUT(PWM_DUTY_OUT), .PWM_FREQ_OUT(PWM_FREQ_OUT),
    .TIMER_OUT(TIMER_OUT));
`default_nettype wire

// ===== fog_load_model.sv
// load and wake source behind the pin
`default_nettype none
module fog_load_model (
    input wire logic low_oe_in,
    input wire logic high_oe_in,
    input wire logic src_lvl_in,
    input wire logic short_in,
    input wire logic open_in,
    output logic level_out,
    output logic oc_out,
    output logic ol_out
);
    // conducting switch beats weak wake source
    assign level_out = high_oe_in ? 1'b1 : (low_oe_in ? 1'b0 : src_lvl_in);
    // comparators see current only while conducting
    assign oc_out = short_in && (low_oe_in || high_oe_in);
    assign ol_out = open_in && high_oe_in;
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench of the pin function block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fog_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, srst = 0, fail = 0, pwm = 0, tmr = 0, src = 0, shrt = 0, opn = 0;
    logic lvl, oc, ol, lo, hi, pu, pd, wk, dg, ls, it, sw;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, duty, freq, tmv;
    fog_mode_t mode = FOG_MODE_NORMAL;
    int errors = 0, checks_done = 0;
    // ctrl, pwm, timer, then low hi wake diag pu pd
    logic [15:0] rows [13] = '{16'h0000, 16'h0820, 16'h0a20, 16'h0c00, 16'h1509, 16'h250a, 16'h06a4,
        16'h0604, 16'h0794, 16'h0704, 16'h0354, 16'h0384, 16'h0180};
    fog_top i_fog_top (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .MODE_IN(mode), .SOFT_RESET_IN(srst), .FAILURE_IN(fail),
        .PWM_ON_IN(pwm), .TIMER_ON_IN(tmr), .OVERCURRENT_IN(oc), .OPEN_LOAD_IN(ol), .PIN_LEVEL_IN(lvl),
        .PIN_LOW_OE_OUT(lo), .PIN_HIGH_OE_OUT(hi), .PULL_UP_OUT(pu), .PULL_DOWN_OUT(pd),
        .WAKE_CAPABLE_OUT(wk), .DIAG_EN_OUT(dg), .LEARN_START_OUT(ls), .INT_OUT(it), .SUPPLY_WAKE_OUT(sw),
        .PWM_DUTY_OUT(duty), .PWM_FREQ_OUT(freq), .TIMER_OUT(tmv));
    fog_load_model i_fog_load_model (.low_oe_in(lo), .high_oe_in(hi), .src_lvl_in(src), .short_in(shrt),
        .open_in(opn), .level_out(lvl), .oc_out(oc), .ol_out(ol));
    // ----
    // tasks
    // ----
    initial forever #25 clk = ~clk;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", n, e, s);
            errors++;
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim;
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bounded wait: interrupt (0), supply wake (1)
    task automatic wait_for(input int n, input int sel, input logic v);
        for (int i = 0; i < n; i++) begin
            tick(1);
            if ((sel ? sw : it) === v) return;
        end
        chk("wait", {7'h0, v}, {7'h0, sel ? sw : it});
        end_sim();
    endtask
    // trip, then re-enable with flags set
    task automatic short_test(input logic [7:0] c);
        logic [7:0] on;
        on = (c[2:0] == 3'h6) ? 8'h02 : 8'h01;
        pwm <= 1'b1;
        tmr <= 1'b1;
        opn <= 1'b1;
        wr_reg(4'h0, c);
        tick(4);
        chk("drive on", on, {6'h0, lo, hi});
        shrt <= 1'b1;
        tick(5);
        chk("tripped", 8'h00, {6'h0, lo, hi});
        shrt <= 1'b0;
        opn <= 1'b0;
        rd_reg(4'h0, {c[7], 7'h04});
        rd_reg(4'h4, {6'h0, c[2:0] == 3'h7, 1'b1});
        tick(500);
        wr_reg(4'h0, {1'b0, c[6:0]});
        wr_reg(4'h0, c);
        tick(4);
        chk("again", on, {6'h0, lo, hi});
        wr_reg(4'h7, 8'h03);
        rd_reg(4'h4, 8'h00);
        wr_reg(4'h0, 8'h04);
        wr_reg(4'h0, 8'h04);
        pwm <= 1'b0;
        tmr <= 1'b0;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk("reset", 8'h00, {lo, hi, wk, dg, pu, pd, it, sw});
        for (int a = 0; a < 6; a++) rd_reg(a[3:0], 8'h00);
        rd_reg(4'hf, 8'h00);
        foreach (rows[i]) begin
            pwm <= rows[i][7];
            tmr <= rows[i][6];
            wr_reg(4'h0, rows[i][15:8]);
            tick(4);
            chk("pins", {2'b00, rows[i][5:0]}, {2'b00, lo, hi, wk, dg, pu, pd});
            rd_reg(4'h0, rows[i][15:8]);
        end
        wr_reg(4'h0, 8'h08);
        shrt <= 1'b1;
        tick(4);
        chk("fail short", 8'h01, {7'h0, lo});
        rd_reg(4'h4, 8'h00);
        shrt <= 1'b0;
        short_test(8'h06);
        short_test(8'h87);
        short_test(8'h03);
        src <= 1'b1;
        wr_reg(4'h0, 8'h05);
        tick(1000);
        chk("blanking", 8'h00, {7'h0, it});
        wait_for(200, 0, 1'b1);
        wait_for(2100, 0, 1'b0);
        rd_reg(4'h5, 8'h01);
        rd_reg(4'h6, 8'h01);
        wr_reg(4'h7, 8'h08);
        mode <= FOG_MODE_RESTART;
        src <= 1'b0;
        tick(400);
        chk("restart int", 8'h00, {7'h0, it});
        mode <= FOG_MODE_INIT;
        rd_reg(4'h5, 8'h01);
        rd_reg(4'h6, 8'h00);
        mode <= FOG_MODE_FAILSAFE;
        tick(3);
        mode <= FOG_MODE_NORMAL;
        rd_reg(4'h5, 8'h00);
        mode <= FOG_MODE_SLEEP;
        src <= 1'b1;
        wait_for(400, 1, 1'b1);
        mode <= FOG_MODE_NORMAL;
        wr_reg(4'h0, 8'h04);
        wr_reg(4'h7, 8'h08);
        fail <= 1'b1;
        tick(4);
        chk("off on failure", 8'h00, {7'h0, lo});
        rd_reg(4'h4, 8'h04);
        fail <= 1'b0;
        wr_reg(4'h7, 8'h04);
        rd_reg(4'h4, 8'h00);
        wr_reg(4'h0, 8'h00);
        fail <= 1'b1;
        mode <= FOG_MODE_RESTART;
        tick(4);
        mode <= FOG_MODE_NORMAL;
        fail <= 1'b0;
        tick(4);
        chk("fail held", 8'h01, {7'h0, lo});
        rd_reg(4'h0, 8'h00);
        wr_reg(4'h7, 8'h04);
        tick(3);
        chk("fail released", 8'h00, {7'h0, lo});
        wr_reg(4'h0, 8'h83);
        wr_reg(4'h1, 8'h40);
        wr_reg(4'h2, 8'h12);
        wr_reg(4'h3, 8'h05);
        tick(1);
        chk("learning", 8'h01, {7'h0, ls});
        chk("settings", 8'h40 ^ 8'h12 ^ 8'h05, duty ^ freq ^ tmv);
        srst <= 1'b1;
        tick(1);
        srst <= 1'b0;
        rd_reg(4'h0, 8'h83);
        rd_reg(4'h1, 8'h00);
        rd_reg(4'h3, 8'h00);
        wr_reg(4'h0, 8'h04);
        wr_reg(4'h0, 8'h04);
        mode <= FOG_MODE_STOP;
        wr_reg(4'h0, 8'h06);
        wr_reg(4'h1, 8'h33);
        mode <= FOG_MODE_NORMAL;
        rd_reg(4'h0, 8'h04);
        rd_reg(4'h1, 8'h00);
        pwm <= 1'b1;
        wr_reg(4'h0, 8'h07);
        tick(3);
        mode <= FOG_MODE_RESTART;
        tick(4);
        chk("restart switch", 8'h00, {7'h0, hi});
        mode <= FOG_MODE_NORMAL;
        rd_reg(4'h0, 8'h04);
        end_sim();
    end
endmodule
`default_nettype wire
